// ---- src/rslfs_pkg.sv ----
// Purpose: Shared constants and types for the link fault reconciliation block
// Assumes: One 32-bit column (4 lanes) per clock, lane 0 in bits 7:0
// Notes:   Register byte address is four times the register index
package rslfs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [11:0] RSLFS_CFG_IDX      = 12'h405;
    localparam logic [13:0] RSLFS_CFG_ADDR     = {RSLFS_CFG_IDX, 2'b00};
    localparam logic [13:0] RSLFS_STAT_ADDR    = 14'h1018;
    localparam logic [13:0] RSLFS_MASK_ADDR    = 14'h101c;
    localparam logic [13:0] RSLFS_STATE_ADDR   = 14'h1020;
    localparam int          RSLFS_ADDR_W       = 14;

    // Configuration field positions and values
    localparam int          RSLFS_CFG_GEN_BIT  = 0;
    localparam int          RSLFS_CFG_UNI_BIT  = 1;
    localparam logic [1:0]  RSLFS_MODE_BIDIR   = 2'b01;
    localparam logic [1:0]  RSLFS_MODE_UNIDIR  = 2'b11;
    localparam logic [1:0]  RSLFS_CFG_RESET    = 2'b00;

    // Event bits in status and mask
    localparam int          RSLFS_EV_LOCAL     = 0;
    localparam int          RSLFS_EV_REMOTE    = 1;
    localparam int          RSLFS_EV_OK        = 2;
    localparam int          RSLFS_EV_W         = 3;
    localparam logic [2:0]  RSLFS_EV_RESET     = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Column coding
    localparam logic [7:0]  RSLFS_SEQ_CHAR     = 8'h9c;
    localparam logic [7:0]  RSLFS_IDLE_CHAR    = 8'h07;
    localparam logic [7:0]  RSLFS_LOCAL_CODE   = 8'h01;
    localparam logic [7:0]  RSLFS_REMOTE_CODE  = 8'h02;
    localparam logic [3:0]  RSLFS_SEQ_CTRL     = 4'h1;
    localparam logic [3:0]  RSLFS_IDLE_CTRL    = 4'hf;
    localparam logic [31:0] RSLFS_IDLE_COL     = 32'h07070707;
    localparam logic [31:0] RSLFS_RF_COL       = 32'h0200009c;

    // Column counts
    localparam logic [7:0]  RSLFS_COL_WINDOW   = 8'd128;
    localparam logic [2:0]  RSLFS_SEQ_NEEDED   = 3'd4;

    // Link fault state
    typedef enum logic [2:0] {
        RSLFS_OK     = 3'b001,
        RSLFS_LOCAL  = 3'b010,
        RSLFS_REMOTE = 3'b100
    } rslfs_fault_type;

endpackage : rslfs_pkg

// ---- src/rslfs_top.sv ----
// Purpose: Reconciliation fault logic between MAC and PCS lanes, AHB-Lite registers
// Assumes: Receive and transmit MAC sides share sys_clk; lanes come from same-clock logic
// Notes:   Reads take one wait state, writes none; response always OKAY
//
// Operation
// RULE1: Fault signaling off until config bit zero set
// RULE2: Bidirectional mode sends remote fault on local fault
// RULE3: Bidirectional mode sends idle during remote fault
// RULE4: Unidirectional mode inserts fault sets into gaps
// RULE5: Received fault sequence sets matching status flag
// RULE6: Over 127 valid columns clear fault status
// RULE7: Four same-value sequences, under 128 apart, set fault
// RULE8: 128 columns without fault sequence return OK
// RULE9: Status follows receive side, ignores configuration
// RULE10: Unidirectional enable output mirrors config bit one
// RULE11: Generation enable output mirrors config bit zero
// RULE12: Watch receive lanes, drive transmit lanes
// RULE13: Reset clears status and leaves link OK
`timescale 1ns/100ps

module rslfs_top
    import rslfs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    // Receive lanes from PCS
    input  wire logic [31:0] rx_d,
    input  wire logic [3:0]  rx_c,
    // Transmit lanes from MAC and toward PCS
    input  wire logic [31:0] mac_tx_d,
    input  wire logic [3:0]  mac_tx_c,
    output logic      [31:0] tx_d,
    output logic      [3:0]  tx_c,
    // Fault status and enables
    output logic             remote_fault_status,
    output logic             local_fault_status,
    output logic             unidirectional_en,
    output logic             link_fault_gen_en
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    // Every output comes straight from one of these flops, so neither
    // side sees a combinational path through the block
    logic [1:0]            cfg_q;
    logic [RSLFS_EV_W-1:0] stat_q;
    logic [RSLFS_EV_W-1:0] stat_d;
    logic [RSLFS_EV_W-1:0] mask_q;
    logic                  irq_q;
    logic [31:0]           hrdata_q;
    logic                  hready_q;
    logic                  hresp_q;
    logic                  wr_pend_q;
    logic                  rd_pend_q;
    logic [RSLFS_ADDR_W-1:0] addr_q;

    // Receive tracking
    // The newest fault value is kept, so a differing value
    // restarts the run instead of extending it
    rslfs_fault_type       fault_q;
    rslfs_fault_type       fault_d;
    rslfs_fault_type       last_seq_q;
    logic [2:0]            seq_cnt_q;
    logic [2:0]            seq_cnt_d;
    logic [7:0]            col_cnt_q;
    logic [7:0]            col_cnt_d;
    logic                  rf_stat_q;
    logic                  lf_stat_q;

    // Transmit lanes
    // One column of latency on the transmit path in every mode
    logic [31:0]           tx_d_q;
    logic [3:0]            tx_c_q;
    logic                  uni_q;
    logic                  gen_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive column decode
    wire logic             seq_col;
    wire logic             rx_local;
    wire logic             rx_remote;
    wire rslfs_fault_type  rx_value;
    wire logic             same_run;
    wire logic             window_done;
    wire logic             fault_col;

    // Sequence set: control in lane 0 only, zero in lanes 1 and 2
    assign seq_col   = (rx_c == RSLFS_SEQ_CTRL) && (rx_d[7:0] == RSLFS_SEQ_CHAR)
                       && (rx_d[23:8] == 16'h0000);                                 // RULE12
    assign rx_local  = seq_col && (rx_d[31:24] == RSLFS_LOCAL_CODE);               // RULE5
    assign rx_remote = seq_col && (rx_d[31:24] == RSLFS_REMOTE_CODE);              // RULE5
    // Other codes in lane 3 count as valid data
    assign fault_col = rx_local || rx_remote;
    assign rx_value  = rx_remote ? RSLFS_REMOTE : RSLFS_LOCAL;
    // A run continues only with same value and a gap under 128 columns
    assign same_run  = (rx_value == last_seq_q) && (col_cnt_q < RSLFS_COL_WINDOW)
                       && (seq_cnt_q != 3'd0);                                      // RULE7
    // The 128th column without a fault set closes the window; a fault
    // set in that same column keeps both flags and the state
    assign window_done = !fault_col && (col_cnt_q == RSLFS_COL_WINDOW - 8'd1);      // RULE6

    // Next state of the fault tracker
    always_comb begin
        // Hold by default; only fault sets and a closed window move it
        fault_d   = fault_q;
        seq_cnt_d = seq_cnt_q;
        col_cnt_d = col_cnt_q;
        if (rx_local || rx_remote) begin
            col_cnt_d = 8'd0;
            // Count saturates at four; more sets of one value change nothing
            seq_cnt_d = same_run ? seq_cnt_q + 3'd1 : 3'd1;                         // RULE7
            if (seq_cnt_d >= RSLFS_SEQ_NEEDED) begin
                seq_cnt_d = RSLFS_SEQ_NEEDED;
                fault_d   = rx_value;                                               // RULE7
            end
        end else if (col_cnt_q != RSLFS_COL_WINDOW) begin
            col_cnt_d = col_cnt_q + 8'd1;
            if (window_done) begin
                fault_d   = RSLFS_OK;                                               // RULE8
                seq_cnt_d = 3'd0;
            end
        end
    end

    // Fault tracker state; saturating column counter keeps a long quiet link idle
    // Reset leaves the counter saturated, so no window closes and no
    // OK event is raised in the first columns after reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fault_q    <= RSLFS_OK;                                                 // RULE13
            last_seq_q <= RSLFS_OK;
            seq_cnt_q  <= 3'd0;
            col_cnt_q  <= RSLFS_COL_WINDOW;
        end else begin
            fault_q    <= fault_d;
            seq_cnt_q  <= seq_cnt_d;
            col_cnt_q  <= col_cnt_d;
            if (rx_local || rx_remote) begin
                last_seq_q <= rx_value;
            end
        end
    end

    // Real-time status flags, independent of configuration
    // One quiet counter serves both flags: a steady run of one fault
    // value also holds the other flag, as fault columns are not data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rf_stat_q <= 1'b0;                                                      // RULE13
            lf_stat_q <= 1'b0;                                                      // RULE13
        end else begin
            if (rx_remote) begin
                rf_stat_q <= 1'b1;                                                  // RULE9
            end else if (window_done) begin
                rf_stat_q <= 1'b0;                                                  // RULE6
            end
            if (rx_local) begin
                lf_stat_q <= 1'b1;                                                  // RULE9
            end else if (window_done) begin
                lf_stat_q <= 1'b0;                                                  // RULE6
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit column selection
    wire logic [1:0]       mode;
    wire logic             tx_idle_col;
    wire logic             send_rf;
    wire logic             send_idle;

    // Both configuration bits select the mode together
    assign mode        = cfg_q;
    // A gap is a full idle column from the MAC
    assign tx_idle_col = (mac_tx_c == RSLFS_IDLE_CTRL) && (mac_tx_d == RSLFS_IDLE_COL);
    // Bidirectional mode replaces all traffic; unidirectional only fills gaps
    assign send_rf     = (fault_q == RSLFS_LOCAL)
                         && ((mode == RSLFS_MODE_BIDIR)                             // RULE2
                             || ((mode == RSLFS_MODE_UNIDIR) && tx_idle_col));      // RULE4
    // A remote fault holds frames back only in bidirectional mode
    assign send_idle   = (fault_q == RSLFS_REMOTE) && (mode == RSLFS_MODE_BIDIR);  // RULE3

    // Transmit lanes; with bit zero clear MAC traffic passes untouched
    // Columns are replaced whole; lanes are never mixed
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_d_q <= RSLFS_IDLE_COL;
            tx_c_q <= RSLFS_IDLE_CTRL;
        end else if (send_rf) begin
            tx_d_q <= RSLFS_RF_COL;                                                 // RULE1
            tx_c_q <= RSLFS_SEQ_CTRL;
        end else if (send_idle) begin
            tx_d_q <= RSLFS_IDLE_COL;                                               // RULE1
            tx_c_q <= RSLFS_IDLE_CTRL;
        end else begin
            tx_d_q <= mac_tx_d;                                                     // RULE12
            tx_c_q <= mac_tx_c;
        end
    end

    // Enable outputs copied from configuration
    // One cycle behind the register, like every other output
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            uni_q <= 1'b0;
            gen_q <= 1'b0;
        end else begin
            uni_q <= cfg_q[RSLFS_CFG_UNI_BIT];                                      // RULE10
            gen_q <= cfg_q[RSLFS_CFG_GEN_BIT];                                      // RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    // Only whole words are expected; hsize is not decoded. Address bits
    // above bit 13 are ignored, so the map repeats through the space
    wire logic             addr_phase;
    wire logic             wr_cfg;
    wire logic             wr_stat;
    wire logic             wr_mask;
    wire logic [31:0]      rd_mux;
    wire logic [RSLFS_EV_W-1:0] events;
    wire logic [RSLFS_EV_W-1:0] clr_bits;
    wire logic [31:0]      state_word;

    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_cfg     = wr_pend_q && (addr_q == RSLFS_CFG_ADDR);
    assign wr_stat    = wr_pend_q && (addr_q == RSLFS_STAT_ADDR);
    assign wr_mask    = wr_pend_q && (addr_q == RSLFS_MASK_ADDR);
    // Write data stands one cycle after its address phase
    assign clr_bits   = wr_stat ? hwdata[RSLFS_EV_W-1:0] : RSLFS_EV_RESET;
    // State word: flags in bits 1:0, link state one-hot in bits 6:4
    assign state_word = {24'h000000, 1'b0, fault_q, 2'b00, rf_stat_q, lf_stat_q};

    // Read decode; unmapped addresses read zero
    // The address is taken in the address phase, used a cycle later
    assign rd_mux = (addr_q == RSLFS_CFG_ADDR)   ? {30'h00000000, cfg_q} :
                    (addr_q == RSLFS_STAT_ADDR)  ? {29'h00000000, stat_q} :
                    (addr_q == RSLFS_MASK_ADDR)  ? {29'h00000000, mask_q} :
                    (addr_q == RSLFS_STATE_ADDR) ? state_word : 32'h00000000;

    // Bus phase tracking; one read wait state lets a preceding write land first
    // Ready drops only in the cycle after a read address phase
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= '0;
            hready_q  <= 1'b1;
            hresp_q   <= 1'b0;
        end else begin
            wr_pend_q <= addr_phase && hwrite;
            rd_pend_q <= addr_phase && !hwrite;
            hready_q  <= !(addr_phase && !hwrite);
            hresp_q   <= 1'b0;
            if (addr_phase) begin
                addr_q <= haddr[RSLFS_ADDR_W-1:0];
            end
        end
    end

    // Read data captured in the wait cycle
    // Holds until the next read completes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_pend_q) begin
            hrdata_q <= rd_mux;
        end
    end

    // Configuration and mask registers
    // Writes to unmapped or read-only words are dropped
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_q  <= RSLFS_CFG_RESET;                                              // RULE1
            mask_q <= RSLFS_EV_RESET;
        end else begin
            if (wr_cfg) begin
                cfg_q <= hwdata[1:0];
            end
            if (wr_mask) begin
                mask_q <= hwdata[RSLFS_EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky events; a set in the clearing cycle wins
    // Events come from the state change, so each entry is caught once
    assign events[RSLFS_EV_LOCAL]  = (fault_d == RSLFS_LOCAL)  && (fault_q != RSLFS_LOCAL);
    assign events[RSLFS_EV_REMOTE] = (fault_d == RSLFS_REMOTE) && (fault_q != RSLFS_REMOTE);
    assign events[RSLFS_EV_OK]     = (fault_d == RSLFS_OK)     && (fault_q != RSLFS_OK);

    // A status bit clears only where a one is written
    genvar gi;
    generate
        for (gi = 0; gi < RSLFS_EV_W; gi++) begin : g_stat
            assign stat_d[gi] = events[gi] | (stat_q[gi] & ~clr_bits[gi]);
        end
    endgenerate

    // Status and interrupt flops
    // The interrupt follows next status so it rises with the bit; a new
    // mask value takes effect one cycle after it is written
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stat_q <= RSLFS_EV_RESET;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q  <= |(stat_d & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    // Plain wires from flops; no logic between flop and pin
    assign hrdata              = hrdata_q;
    assign hreadyout           = hready_q;
    assign hresp               = hresp_q;
    assign irq                 = irq_q;
    assign tx_d                = tx_d_q;
    assign tx_c                = tx_c_q;
    assign remote_fault_status = rf_stat_q;
    assign local_fault_status  = lf_stat_q;
    assign unidirectional_en   = uni_q;
    assign link_fault_gen_en   = gen_q;

endmodule : rslfs_top

// ---- tb/rslfs_pcs_model.sv ----
// Purpose: Far-side PCS model feeding receive columns
// Assumes: kind 0 idle, 1 local fault, 2 remote fault, 3 data
// Notes:   Data columns change every cycle so a stuck lane shows
`timescale 1ns/100ps
module rslfs_pcs_model
    import rslfs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [1:0]  kind,
    output logic      [31:0] rx_d,
    output logic      [3:0]  rx_c
);
    logic [31:0] cnt_q;
    ////////////////////////////////////////
    // Moving pattern for data columns
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) cnt_q <= 32'h00000000;
        else cnt_q <= cnt_q + 32'h01010101;
    end
    // Fault sets carry their code in lane 3
    assign rx_d = kind == 2'h3 ? cnt_q : kind == 2'h0 ? RSLFS_IDLE_COL :
        {kind == 2'h1 ? RSLFS_LOCAL_CODE : RSLFS_REMOTE_CODE, 16'h0000, RSLFS_SEQ_CHAR};
    assign rx_c = kind == 2'h3 ? 4'h0 : kind == 2'h0 ? RSLFS_IDLE_CTRL : RSLFS_SEQ_CTRL;
endmodule : rslfs_pcs_model

// ---- tb/rslfs_checker.sv ----
// Purpose: Concurrent checks on the fault block ports
// Assumes: One clock, asynchronous active-high reset
// Notes:   Config copy is rebuilt from bus writes
`timescale 1ns/100ps
module rslfs_checker
    import rslfs_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic [31:0] rx_d,
    input wire logic [3:0]  rx_c,
    input wire logic [31:0] mac_tx_d,
    input wire logic [3:0]  mac_tx_c,
    input wire logic [31:0] tx_d,
    input wire logic [3:0]  tx_c,
    input wire logic        remote_fault_status,
    input wire logic        local_fault_status,
    input wire logic        unidirectional_en,
    input wire logic        link_fault_gen_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [1:0] cfg_q;
    logic       cfg_wr_q;
    logic [7:0] quiet_q;
    // Address phase hit and fault column decode
    wire cfg_hit = hsel && htrans[1] && hready && hwrite && haddr == 32'(RSLFS_CFG_ADDR);
    wire loc_seq = rx_c == RSLFS_SEQ_CTRL && rx_d == {RSLFS_LOCAL_CODE, 16'h0, RSLFS_SEQ_CHAR};
    wire rem_seq = rx_c == RSLFS_SEQ_CTRL && rx_d == {RSLFS_REMOTE_CODE, 16'h0, RSLFS_SEQ_CHAR};
    ////////////////////////////////////////
    // Config shadow and quiet count, saturating so it never wraps
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_wr_q <= 1'b0;
            cfg_q    <= RSLFS_CFG_RESET;
            quiet_q  <= 8'h00;
        end else begin
            cfg_wr_q <= cfg_hit;
            if (cfg_wr_q) cfg_q <= hwdata[1:0];
            quiet_q <= (loc_seq || rem_seq) ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hff};
        end
    end
    ////////////////////////////////////////
    gen_mirror_a: assert property (link_fault_gen_en == $past(cfg_q[0]))
        else $error("generation enable not following config");
    uni_mirror_a: assert property (unidirectional_en == $past(cfg_q[1]))
        else $error("unidirectional enable not following config");
    local_flag_a: assert property (loc_seq |=> local_fault_status)
        else $error("local flag missing");
    remote_flag_a: assert property (rem_seq |=> remote_fault_status)
        else $error("remote flag missing");
    quiet_clear_a: assert property (quiet_q > 8'd128 |-> !local_fault_status && !remote_fault_status)
        else $error("flag kept after quiet span");
    early_clear_a: assert property ($fell(local_fault_status) |-> $past(quiet_q) >= 8'd127)
        else $error("flag cleared too early");
    pass_off_a: assert property ($past(cfg_q) == 2'b00 |-> tx_d == $past(mac_tx_d))
        else $error("transmit altered while disabled");
    uni_data_a: assert property ($past(cfg_q) == 2'b11 && $past(mac_tx_c) == 4'h0 |-> tx_d == $past(mac_tx_d))
        else $error("data replaced in unidirectional mode");
    rd_wait_a: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    cover property (loc_seq ##1 local_fault_status);
    cover property ($fell(local_fault_status));
    cover property (tx_d == RSLFS_RF_COL);
endmodule : rslfs_checker

bind rslfs_top rslfs_checker chk_i (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hwdata, .hreadyout, .rx_d, .rx_c, .mac_tx_d, .mac_tx_c, .tx_d, .tx_c,
    .remote_fault_status, .local_fault_status, .unidirectional_en, .link_fault_gen_en);

// ---- tb/rs_link_fault_signaling_test.sv ----
// Purpose: Self-checking bench for the fault reconciliation block
// Assumes: Read answers after one wait state, writes at once
// Notes:   Outputs are looked at 1 ns after the edge
`timescale 1ns/100ps
module rs_link_fault_signaling_test
    import rslfs_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [1:0]  kind = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] mac_tx_d = RSLFS_IDLE_COL;
    logic [3:0]  mac_tx_c = RSLFS_IDLE_CTRL;
    logic [31:0] hrdata, rx_d, tx_d, rd;
    logic [3:0]  rx_c, tx_c;
    logic        hreadyout, hresp, irq, rem_st, loc_st, uni_en, gen_en;
    int          n_mismatch = 0;
    int          check_count = 0;
    localparam logic [31:0] DAT = 32'h5a5aa5a5;

    always #2.5 sys_clk = ~sys_clk;
    rslfs_pcs_model pcs (.sys_clk, .rst, .kind, .rx_d, .rx_c);
    rslfs_top uut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .irq, .rx_d, .rx_c,
        .mac_tx_d, .mac_tx_c, .tx_d, .tx_c, .remote_fault_status(rem_st),
        .local_fault_status(loc_st), .unidirectional_en(uni_en), .link_fault_gen_en(gen_en));
    ////////////////////////////////////////
    task automatic chk(input bit ok, input string what);
        check_count++;
        if (!ok) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : chk
    // Single word transfer; request held until hready is seen high
    task automatic bus(input bit wr, input logic [13:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {18'h0, a};
        hwrite <= wr;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask : bus
    task automatic cols(input logic [1:0] k, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            kind <= k;
        end
    endtask : cols
    // Fault sets ten columns apart, well inside the window
    task automatic seqs(input logic [1:0] k, input int n);
        repeat (n) begin
            cols(k, 1);
            cols(2'h3, 9);
        end
    endtask : seqs
    ////////////////////////////////////////
    task automatic t_reset;
        #1;
        chk(gen_en === 1'b0 && uni_en === 1'b0 && loc_st === 1'b0 && rem_st === 1'b0, "rst");
        bus(1'b0, RSLFS_CFG_ADDR, 32'h0);
        chk(rd === 32'h0 && hresp === 1'b0, "config reset");
        bus(1'b0, RSLFS_STATE_ADDR, 32'h0);
        chk(rd === 32'h10, "state reset");
        bus(1'b0, 14'h1040, 32'h0);
        chk(rd === 32'h0, "unmapped read");
        $display("reset test done");
    endtask : t_reset
    task automatic t_bidir;
        @(posedge sys_clk);
        mac_tx_d <= DAT;
        mac_tx_c <= 4'h0;
        bus(1'b1, RSLFS_CFG_ADDR, 32'h1);
        bus(1'b1, RSLFS_MASK_ADDR, 32'h7);
        seqs(2'h1, 1);
        #1;
        chk(gen_en === 1'b1 && uni_en === 1'b0, "bidir enables");
        chk(loc_st === 1'b1 && tx_d === DAT, "first local set");
        seqs(2'h1, 3);
        #1;
        chk(tx_d === RSLFS_RF_COL && tx_c === RSLFS_SEQ_CTRL && irq === 1'b1, "rf out");
        bus(1'b0, RSLFS_STATE_ADDR, 32'h0);
        chk(rd === 32'h21, "state local");
        bus(1'b0, RSLFS_STAT_ADDR, 32'h0);
        chk(rd === 32'h1, "local event");
        bus(1'b1, RSLFS_MASK_ADDR, 32'h0);
        cols(2'h3, 1);
        #1;
        chk(irq === 1'b0, "irq masked");
        bus(1'b1, RSLFS_MASK_ADDR, 32'h7);
        bus(1'b1, RSLFS_STAT_ADDR, 32'h1);
        cols(2'h3, 1);
        #1;
        chk(irq === 1'b0, "irq cleared");
        $display("bidirectional test done");
    endtask : t_bidir
    task automatic t_clear;
        seqs(2'h1, 1);
        cols(2'h3, 117);
        #1;
        chk(loc_st === 1'b1, "flag held at 125 quiet");
        cols(2'h3, 4);
        #1;
        chk(loc_st === 1'b0 && tx_d === DAT, "cleared after 129 quiet");
        $display("clear test done");
    endtask : t_clear
    task automatic t_remote;
        seqs(2'h1, 3);
        seqs(2'h2, 1);
        seqs(2'h1, 3);
        bus(1'b0, RSLFS_STATE_ADDR, 32'h0);
        chk(rd === 32'h13, "mixed values stay ok");
        seqs(2'h2, 4);
        #1;
        chk(tx_d === RSLFS_IDLE_COL && tx_c === RSLFS_IDLE_CTRL, "idle on remote");
        bus(1'b0, RSLFS_STATE_ADDR, 32'h0);
        chk(rd === 32'h43, "state remote");
        $display("remote test done");
    endtask : t_remote
    task automatic t_unidir;
        cols(2'h3, 130);
        bus(1'b1, RSLFS_CFG_ADDR, 32'h3);
        seqs(2'h1, 4);
        #1;
        chk(uni_en === 1'b1 && tx_d === DAT, "uni data passes");
        @(posedge sys_clk);
        mac_tx_d <= RSLFS_IDLE_COL;
        mac_tx_c <= RSLFS_IDLE_CTRL;
        cols(2'h3, 2);
        #1;
        chk(tx_d === RSLFS_RF_COL && tx_c === RSLFS_SEQ_CTRL, "uni gap filled");
        bus(1'b1, RSLFS_CFG_ADDR, 32'h0);
        seqs(2'h2, 1);
        #1;
        chk(gen_en === 1'b0 && tx_d === RSLFS_IDLE_COL && rem_st === 1'b1, "off");
        $display("unidirectional test done");
    endtask : t_unidir
    ////////////////////////////////////////
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset;
        t_bidir;
        t_clear;
        t_remote;
        t_unidir;
        give_verdict;
    end
    // Watchdog well past the roughly 520 cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        give_verdict;
    end
endmodule : rs_link_fault_signaling_test
